// ---- design/audio_port_pkg.sv ----
package audio_port_pkg;

    // Word length selections; one-hot codes.
    typedef enum logic [2:0] {
        WIDTH_8 = 3'h1,
        WIDTH_16 = 3'h2,
        WIDTH_24 = 3'h4
    } word_width_t;

    // One sample word with its channel tag (high selects the right channel).
    typedef struct packed {
        logic right;
        logic [23:0] data;
    } sample_t;

    // Static configuration of the port.
    typedef struct packed {
        logic enable;
        logic initiator;
        logic stereo_mode;
        word_width_t width;
    } port_cfg_t;

    // Fractional divider setting: the bit clock toggles inc/modulus times per system clock.
    typedef struct packed {
        logic [15:0] inc;
        logic [15:0] modulus;
    } divider_t;

    localparam int unsigned SAMPLE_BITS = 24;
    localparam logic [4:0] BIT_IDLE = 5'h1F;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_24 = 5'h18;
    localparam logic [1:0] FILL_EMPTY = 2'h0;
    localparam logic [1:0] FILL_ONE = 2'h1;
    localparam logic [1:0] FILL_FULL = 2'h2;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic [23:0] SAMPLE_ZERO = 24'h000000;

    // Number of bits in one word for a width selection.
    function automatic logic [4:0] word_bits(input word_width_t w);
        case (w)
            WIDTH_8: word_bits = BITS_8;
            WIDTH_16: word_bits = BITS_16;
            default: word_bits = BITS_24;
        endcase
    endfunction

    // A word starts on any level change in stereo mode, on a rising pulse otherwise.
    function automatic logic frame_event(input logic stereo, input logic now, input logic prev);
        frame_event = stereo ? (now != prev) : (now & ~prev);
    endfunction

endpackage

// ---- design/sample_buffer.sv ----
`timescale 1ns/100ps
module sample_buffer import audio_port_pkg::*; (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire sample_t in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output sample_t out_data
);

    logic [1:0] fill_r;
    logic [1:0] fill_nxt;
    sample_t tail_r;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Occupancy count after this cycle's push and pop.
    always_comb begin
        fill_nxt = fill_r;
        if (push && !pop) begin
            fill_nxt = fill_r + 2'h1;
        end else if (pop && !push) begin
            fill_nxt = fill_r - 2'h1;
        end
    end

    // Count and the registered flags, so both handshake outputs come from flip-flops.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fill_r <= FILL_EMPTY;
            out_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            fill_r <= fill_nxt;
            out_valid <= (fill_nxt != FILL_EMPTY);
            in_ready <= (fill_nxt != FILL_FULL);
        end
    end

    // Head and tail entries; the head is always the oldest word.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_data <= '0;
            tail_r <= '0;
        end else begin
            if (fill_r == FILL_FULL && pop) begin
                out_data <= tail_r;
            end else if (push && (fill_r == FILL_EMPTY || (fill_r == FILL_ONE && pop))) begin
                out_data <= in_data;
            end else if (push) begin
                tail_r <= in_data;
            end
        end
    end

    // A full buffer never accepts a word.
    full_blocks_a: assert property (@(posedge clock) disable iff (!rst_n)
        fill_r == FILL_FULL |-> !in_ready) else $error("buffer accepted while full");

endmodule // sample_buffer

// ---- design/audio_serial_port.sv ----
`timescale 1ns/100ps
// Summary of operation
// R01: Port uses bit clock, frame, data in/out.
// R02: Bit clock driven as initiator, input as target.
// R03: Frame signal driven as initiator, input as target.
// R04: All port signals timed by the bit clock.
// R05: Initiator bit clock from fractional system-clock divider.
// R06: Target mode: outside party supplies bit clock.
// R07: One transmit and one receive stream concurrently.
// R08: Transmit on data out, receive on data in.
// R09: Words shift most significant bit first.
// R10: Word widths of 16 and 24 bits.
// R11: 16-bit linear and 8-bit companded samples.
// R12: Sample rates include 8 kHz and 16 kHz.
// R13: Mono speech, or stereo audio offload.
// R14: Frame events mark words; level selects channel.
module audio_serial_port import audio_port_pkg::*; (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Configuration.
    input wire port_cfg_t cfg,
    input wire divider_t divider,
    // Bit clock pin.
    input wire logic bit_clock_in,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    // Frame pin (word select in stereo mode).
    input wire logic stereo_word_select_in,
    output logic stereo_word_select_out,
    output logic stereo_word_select_oe,
    // Serial data pins.
    input wire logic stereo_serial_in,
    output logic stereo_serial_out,
    // Transmit samples from the user.
    input wire logic tx_valid,
    output logic tx_ready,
    input wire sample_t tx_sample,
    // Received samples to the user.
    output logic rx_valid,
    input wire logic rx_ready,
    output sample_t rx_sample,
    // Status pulses.
    output logic tx_underrun,
    output logic rx_overrun
);

    logic [2:0] bclk_sync_r;
    logic [1:0] fs_sync_r;
    logic [1:0] sdi_sync_r;
    logic [15:0] acc_r;
    logic tick;
    logic [16:0] acc_sum;
    logic rise_ev;
    logic fall_ev;
    logic fs_now;
    logic fs_prev_r;
    logic pend_r;
    logic pend_right_r;
    logic [4:0] bit_r;
    logic [4:0] wbits;
    logic [SAMPLE_BITS-1:0] tx_shift_r;
    logic [SAMPLE_BITS-1:0] rx_shift_r;
    logic word_right_r;
    logic tx_take;
    sample_t tx_head;
    logic tx_head_valid;
    logic rx_push_r;
    sample_t rx_word_r;
    logic rx_buf_ready;

    assign wbits = word_bits(cfg.width); // R10 R11

    // Two-stage synchronisers; the third bit clock stage only feeds edge detection.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bclk_sync_r <= 3'h0;
            fs_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
        end else begin
            bclk_sync_r <= {bclk_sync_r[1:0], bit_clock_in}; // R01
            fs_sync_r <= {fs_sync_r[0], stereo_word_select_in};
            sdi_sync_r <= {sdi_sync_r[0], stereo_serial_in}; // R08
        end
    end

    // Fractional divider: the phase accumulator wraps at the modulus and each wrap toggles the clock.
    assign acc_sum = {1'b0, acc_r} + {1'b0, divider.inc};
    assign tick = cfg.enable && cfg.initiator && (acc_sum >= {1'b0, divider.modulus});

    always_ff @(posedge clock) begin
        if (!rst_n || !cfg.initiator) begin
            acc_r <= ACC_RESET;
        end else if (cfg.enable) begin
            acc_r <= tick ? 16'(acc_sum - {1'b0, divider.modulus}) : acc_sum[15:0]; // R05 R12
        end
    end

    // Bit clock pin: driven only as initiator.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bit_clock_out <= 1'b0;
            bit_clock_oe <= 1'b0;
        end else begin
            bit_clock_oe <= cfg.initiator; // R02
            if (tick) begin
                bit_clock_out <= ~bit_clock_out; // R05
            end
        end
    end

    // Bit clock edges, from the own divider or from the synchronised pin.
    assign rise_ev = cfg.initiator ? (tick && !bit_clock_out) :
        (cfg.enable && bclk_sync_r[1] && !bclk_sync_r[2]); // R04
    assign fall_ev = cfg.initiator ? (tick && bit_clock_out) :
        (cfg.enable && !bclk_sync_r[1] && bclk_sync_r[2]); // R04
    assign fs_now = cfg.initiator ? stereo_word_select_out : fs_sync_r[1];

    // Frame pin: as initiator it toggles (stereo) or pulses (mono) once all bits of a word are done.
    // A start that is already pending holds the pin in stereo and drives it low in mono, so one event never arms two word starts.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stereo_word_select_out <= 1'b0;
            stereo_word_select_oe <= 1'b0;
        end else begin
            stereo_word_select_oe <= cfg.initiator; // R03
            if (fall_ev && cfg.initiator) begin
                if (cfg.stereo_mode) begin
                    stereo_word_select_out <= (bit_r >= wbits && !pend_r) ? ~stereo_word_select_out
                        : stereo_word_select_out; // R13 R14
                end else begin
                    stereo_word_select_out <= (bit_r >= wbits && !pend_r); // R14
                end
            end
        end
    end

    // Frame events seen on a rising edge arm a word start for the next falling edge.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fs_prev_r <= 1'b0;
            pend_r <= 1'b0;
            pend_right_r <= 1'b0;
        end else if (rise_ev) begin
            fs_prev_r <= fs_now;
            if (frame_event(cfg.stereo_mode, fs_now, fs_prev_r)) begin
                pend_r <= 1'b1; // R14
                pend_right_r <= cfg.stereo_mode & fs_now; // R14
            end
        end else if (fall_ev && pend_r) begin
            pend_r <= 1'b0;
        end
    end

    // Transmit: load the next word at a word start, otherwise shift toward the top bit.
    assign tx_take = fall_ev && pend_r && tx_head_valid;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_shift_r <= SAMPLE_ZERO;
            stereo_serial_out <= 1'b0;
            word_right_r <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= fall_ev && pend_r && !tx_head_valid;
            if (fall_ev && pend_r) begin
                word_right_r <= pend_right_r;
                // Samples sit in the low bits; align the top bit of the word to the shifter's top.
                tx_shift_r <= tx_head_valid ? (tx_head.data << (5'(SAMPLE_BITS) - wbits)) : SAMPLE_ZERO; // R09
                stereo_serial_out <= tx_head_valid ? tx_head.data[wbits - 5'h1] : 1'b0; // R08 R09
            end else if (fall_ev && bit_r < wbits && bit_r != 5'h0) begin
                tx_shift_r <= {tx_shift_r[SAMPLE_BITS-2:0], 1'b0};
                stereo_serial_out <= tx_shift_r[SAMPLE_BITS-2]; // R09
            end else if (fall_ev && bit_r >= wbits) begin
                stereo_serial_out <= 1'b0;
            end
        end
    end

    // Receive: sample on rising edges, top bit first, and hand over the word after its last bit.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bit_r <= BIT_IDLE;
            rx_shift_r <= SAMPLE_ZERO;
            rx_push_r <= 1'b0;
            rx_word_r <= '0;
            rx_overrun <= 1'b0;
        end else begin
            rx_push_r <= 1'b0;
            rx_overrun <= 1'b0;
            if (fall_ev && pend_r) begin
                bit_r <= 5'h0;
                rx_shift_r <= SAMPLE_ZERO; // R10 R11
            end else if (rise_ev && bit_r < wbits) begin
                rx_shift_r <= {rx_shift_r[SAMPLE_BITS-2:0], sdi_sync_r[1]}; // R07 R09
                bit_r <= bit_r + 5'h1;
                if (bit_r == wbits - 5'h1) begin
                    rx_push_r <= rx_buf_ready;
                    rx_overrun <= !rx_buf_ready;
                    rx_word_r <= '{right: word_right_r, data: {rx_shift_r[SAMPLE_BITS-2:0], sdi_sync_r[1]}};
                end
            end
        end
    end

    // Transmit path buffer; the user stalls on tx_ready when it holds two words.
    sample_buffer tx_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_sample),
        .out_valid(tx_head_valid),
        .out_ready(tx_take),
        .out_data(tx_head)
    );

    // Receive path buffer; a stalled user fills it and then words are counted as overruns.
    sample_buffer rx_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(rx_push_r),
        .in_ready(rx_buf_ready),
        .in_data(rx_word_r),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_sample)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    bclk_drive_a: assert property (!cfg.initiator ##1 !cfg.initiator |-> !bit_clock_oe)
        else $error("bit clock driven as target"); // R02 R06
    fs_drive_a: assert property ($past(cfg.initiator) && $past(rst_n) |->
        stereo_word_select_oe == $past(cfg.initiator))
        else $error("frame pin drive mismatch"); // R03
    divider_toggle_a: assert property (tick |=> bit_clock_out != $past(bit_clock_out))
        else $error("bit clock missed a divider wrap"); // R05
    divider_hold_a: assert property (cfg.initiator && !tick |=> $stable(bit_clock_out))
        else $error("bit clock moved without a wrap"); // R04 R05
    data_on_fall_a: assert property (!fall_ev |=> $stable(stereo_serial_out))
        else $error("data out changed off a falling edge"); // R04 R08
    msb_first_a: assert property (tx_take |=> stereo_serial_out == $past(tx_head.data[wbits - 5'h1]))
        else $error("first bit is not the top bit"); // R09
    word_len_a: assert property (rx_push_r |-> $past(bit_r) == wbits - 5'h1)
        else $error("received word length wrong"); // R10 R11
    start_word_a: assert property (fall_ev && pend_r |=> bit_r == 5'h0 && !pend_r)
        else $error("word start not taken"); // R14
    channel_tag_a: assert property (rise_ev && cfg.stereo_mode && frame_event(1'b1, fs_now, fs_prev_r)
        |=> pend_right_r == $past(fs_now)) else $error("channel tag not from word select"); // R13 R14
    duplex_a: assert property (rx_push_r |-> rx_buf_ready || $past(bit_r) != wbits - 5'h1)
        else $error("receive word pushed into full buffer"); // R07

endmodule // audio_serial_port

// ---- testbench/audio_host_model.sv ----
`timescale 1ns/100ps
module audio_host_model (
    // Bench side.
    input wire logic rst_n,
    input wire logic drive_clock,
    input wire logic stereo,
    input wire logic [4:0] wbits,
    input wire logic [23:0] word_a,
    input wire logic [23:0] word_b,
    output logic [1:0] cap_n,
    output logic [23:0] cap0,
    output logic [23:0] cap1,
    output logic cap_right0,
    // Pin side.
    input wire logic dev_bclk,
    input wire logic dev_bclk_oe,
    input wire logic dev_ws,
    input wire logic dev_ws_oe,
    input wire logic dev_sdo,
    output logic bclk,
    output logic ws,
    output logic sdi = 1'b0
);
    logic host_clk = 1'b0;
    logic host_ws = 1'b0;
    logic [4:0] slot = 5'h00;
    logic ws_prev = 1'b0;
    logic word_right = 1'b0;
    logic idx = 1'b0;
    logic [4:0] cnt = 5'h1F;
    logic [23:0] shreg = 24'h000000;
    logic [23:0] tx_word;
    logic frame;

    // The host makes the bit clock only while the device is target, and holds it still in reset.
    always #40 host_clk = (rst_n && drive_clock) ? ~host_clk : 1'b0;
    // Whoever enables its driver owns the wire.
    assign bclk = dev_bclk_oe ? dev_bclk : host_clk;
    assign ws = dev_ws_oe ? dev_ws : host_ws;
    assign tx_word = idx ? word_b : word_a;
    assign frame = stereo ? (ws != ws_prev) : (ws && !ws_prev);

    // Word select toggles every 32 bits; a mono sync is high for the bit before each word.
    always @(negedge host_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot <= 5'h00;
            host_ws <= 1'b0;
        end else begin
            slot <= slot + 5'h01;
            host_ws <= stereo ? (host_ws ^ (slot == 5'h1F)) : (slot == 5'h1E);
        end
    end

    // Shift the device's word in at rising edges; a frame event restarts the count.
    always @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            ws_prev <= 1'b0;
            cnt <= 5'h1F;
            idx <= 1'b0;
            cap_n <= 2'h0;
        end else begin
            ws_prev <= ws;
            if (cnt < wbits) begin
                shreg <= {shreg[22:0], dev_sdo};
                cnt <= cnt + 5'h01;
                if (cnt == wbits - 5'h01) begin
                    idx <= ~idx;
                    if (cap_n == 2'h0) begin
                        cap0 <= {shreg[22:0], dev_sdo};
                        cap_right0 <= word_right;
                    end
                    if (cap_n == 2'h1) cap1 <= {shreg[22:0], dev_sdo};
                    if (cap_n != 2'h2) cap_n <= cap_n + 2'h1;
                end
            end
            if (frame) begin
                cnt <= 5'h00;
                shreg <= 24'h000000;
                word_right <= ws;
            end
        end
    end

    // Send the host's word MSB first at falling edges; between words the line keeps changing.
    always @(negedge bclk or negedge rst_n) begin
        if (!rst_n) sdi <= 1'b0;
        else if (cnt < wbits) sdi <= tx_word[wbits - 5'h01 - cnt];
        else sdi <= ~sdi;
    end
endmodule // audio_host_model

// ---- testbench/pcm_i2s_audio_port_bench.sv ----
`timescale 1ns/100ps
module pcm_i2s_audio_port_bench import audio_port_pkg::*;;
    typedef struct packed {
        logic init;
        logic st;
        word_width_t w;
        logic [23:0] t0, t1, r0, r1;
    } row_t;
    row_t rows [5] = '{
        '{1'b1, 1'b1, WIDTH_24, 24'hA5C3F1, 24'h813579, 24'hC0FFE1, 24'h9ABCD3},
        '{1'b0, 1'b1, WIDTH_16, 24'h12B00D, 24'h34F00B, 24'h77A001, 24'h668003},
        '{1'b1, 1'b0, WIDTH_8, 24'h5A5A93, 24'hA5A5C5, 24'h0000D5, 24'hFFFF81},
        '{1'b0, 1'b0, WIDTH_16, 24'h00F00F, 24'h008001, 24'h00C003, 24'h00BEE5},
        '{1'b0, 1'b1, WIDTH_24, 24'h800001, 24'hFEDCBB, 24'h8F0001, 24'hE10087}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    port_cfg_t cfg = '0;
    divider_t divider = '{16'h0001, 16'h000A};
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b1;
    sample_t tx_sample = '0;
    logic drive_clock = 1'b0;
    logic [4:0] wbits = 5'h18;
    logic [23:0] word_a = '0, word_b = '0, msk, cap0, cap1;
    logic bclk, ws, sdi, bclk_out, bclk_oe, ws_out, ws_oe, sdo, tx_ready, rx_valid, tx_underrun, rx_overrun;
    logic [1:0] cap_n;
    logic cap_right0, prev_b;
    sample_t rx_sample;
    sample_t rx_q[$];
    row_t rw;
    int n_under, n_over, n, cnt;
    int n_mismatch = 0, comparisons = 0;

    audio_serial_port u_audio_serial_port (.clock(clock), .rst_n(rst_n), .cfg(cfg), .divider(divider),
        .bit_clock_in(bclk), .bit_clock_out(bclk_out), .bit_clock_oe(bclk_oe), .stereo_word_select_in(ws),
        .stereo_word_select_out(ws_out), .stereo_word_select_oe(ws_oe), .stereo_serial_in(sdi),
        .stereo_serial_out(sdo), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_sample(tx_sample),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_sample(rx_sample), .tx_underrun(tx_underrun),
        .rx_overrun(rx_overrun));
    audio_host_model u_audio_host_model (.rst_n(rst_n), .drive_clock(drive_clock), .stereo(cfg.stereo_mode),
        .wbits(wbits), .word_a(word_a), .word_b(word_b), .cap_n(cap_n), .cap0(cap0), .cap1(cap1),
        .cap_right0(cap_right0), .dev_bclk(bclk_out), .dev_bclk_oe(bclk_oe), .dev_ws(ws_out),
        .dev_ws_oe(ws_oe), .dev_sdo(sdo), .bclk(bclk), .ws(ws), .sdi(sdi));

    // System clock of 200 MHz.
    always #2.5 clock = ~clock;

    // Collect received samples and count status pulses.
    always @(posedge clock) begin
        if (rst_n !== 1'b1) begin
            rx_q.delete();
            n_under = 0;
            n_over = 0;
        end else begin
            if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_sample);
            n_under += (tx_underrun === 1'b1);
            n_over += (rx_overrun === 1'b1);
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic give_up(input string what);
        check(what, 32'h0, 32'h1);
        final_report();
    endtask

    // Reset for eight cycles; outputs are idle and the transmit side is ready meanwhile.
    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (8) @(negedge clock);
        check("tx_ready_rst", tx_ready, 1'b1);
        check("idle_rst", {rx_valid, tx_underrun, rx_overrun, bclk_oe, ws_oe}, 5'h00);
        rst_n = 1'b1;
    endtask

    // Offer one word and hold it until the edge that takes it.
    task automatic push(input logic [23:0] d);
        @(negedge clock);
        tx_valid = 1'b1;
        tx_sample = '{1'b0, d};
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (tx_ready === 1'b1) break;
        end
        if (n == 100) give_up("tx_accept");
    endtask

    // Set the port up from a row and reset it.
    task automatic setup(input row_t r);
        @(negedge clock);
        rw = r;
        wbits = (r.w == WIDTH_8) ? 5'h08 : (r.w == WIDTH_16) ? 5'h10 : 5'h18;
        msk = 24'hFFFFFF >> (5'h18 - wbits);
        cfg = '{1'b1, r.init, r.st, r.w};
        drive_clock = ~r.init;
        word_a = r.r0;
        word_b = r.r1;
        do_reset();
    endtask

    initial begin
        // Each row runs two words each way in one mode, width and clocking.
        foreach (rows[i]) begin
            setup(rows[i]);
            repeat (4) @(negedge clock);
            check("bclk_oe", bclk_oe, rw.init);
            check("ws_oe", ws_oe, rw.init);
            push(rw.t0);
            push(rw.t1);
            @(negedge clock);
            tx_valid = 1'b0;
            for (n = 0; n < 40000 && !(cap_n == 2'h2 && rx_q.size() >= 2); n++) @(posedge clock);
            if (n == 40000) give_up("words");
            check("tx_word0", cap0, rw.t0 & msk);
            check("tx_word1", cap1, rw.t1 & msk);
            check("rx_word0", rx_q[0].data, rw.r0 & msk);
            check("rx_word1", rx_q[1].data, rw.r1 & msk);
            if (rw.st) check("channels", {rx_q[0].right, rx_q[1].right, cap_right0}, 3'h5);
        end
        // Fractional ratio, a refused third word, then underrun and overrun with the receiver stalled.
        @(negedge clock);
        divider = '{16'h0003, 16'h0014};
        rx_ready = 1'b0;
        setup(rows[0]);
        push(rw.t0);
        push(rw.t1);
        @(negedge clock);
        tx_sample = '{1'b0, 24'h3C3C3C};
        repeat (3) @(negedge clock);
        check("tx_ready_full", tx_ready, 1'b0);
        for (n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(posedge clock);
        if (n == 2000) give_up("tx_space");
        @(negedge clock);
        tx_valid = 1'b0;
        cnt = 0;
        prev_b = bclk_out;
        for (n = 0; n < 600; n++) begin
            @(posedge clock);
            if (bclk_out === 1'b1 && prev_b === 1'b0) cnt++;
            prev_b = bclk_out;
        end
        check("bclk_rate", (cnt >= 44 && cnt <= 46), 1'b1);
        for (n = 0; n < 4000 && !(n_under > 0 && n_over > 0); n++) @(posedge clock);
        check("underrun", n_under > 0, 1'b1);
        check("overrun", n_over > 0, 1'b1);
        check("rx_held", {rx_valid, rx_sample.data}, {1'b1, rw.r0});
        check("tx_first", cap0, rw.t0);
        // A disabled port stops its own bit clock.
        @(negedge clock);
        cfg.enable = 1'b0;
        repeat (2) @(negedge clock);
        prev_b = bclk_out;
        cnt = 0;
        for (n = 0; n < 100; n++) begin
            @(negedge clock);
            cnt += (bclk_out !== prev_b);
        end
        check("bclk_stopped", cnt, 32'h0);
        final_report();
    end
endmodule // pcm_i2s_audio_port_bench
